// >>> core/tif_pkg.sv
// Package with register map and constants of the timer interrupt flag block
package tif_pkg;
  localparam logic [11:0] TIF_OFS_FLAGS   = 12'h000;
  localparam logic [11:0] TIF_OFS_PRIO    = 12'h004;
  localparam logic [11:0] TIF_OFS_EVT_ST  = 12'h008;
  localparam logic [11:0] TIF_OFS_EVT_MSK = 12'h00C;
  localparam logic [11:0] TIF_OFS_TIMER   = 12'h010;
  localparam int          TIF_NUM_TIMERS  = 5;
  localparam int          TIF_FLAG_POS [TIF_NUM_TIMERS] = '{4, 8, 12, 16, 20};
  localparam int          TIF_PRIO_LSB    = 2;
  localparam int          TIF_PRIO_MSB    = 4;
  localparam int          TIF_SUB_LSB     = 0;
  localparam int          TIF_SUB_MSB     = 1;
  localparam logic [31:0] TIF_TIMER_MASK  = 32'h0011_1110;
  localparam logic [31:0] TIF_PRIO_MASK   = 32'h0000_001F;
  localparam logic [31:0] TIF_FLAGS_RST   = 32'h0000_0000;
  localparam logic [31:0] TIF_PRIO_RST    = 32'h0000_0000;
  localparam logic [4:0]  TIF_EVT_RST     = 5'h00;
endpackage

// >>> core/tif_event_sync.sv
// Two-flop synchroniser and rising-edge pulse for one timer event input
`timescale 1ns/1ps
module tif_event_sync
  import tif_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic evt_in,
  output logic      evt_pulse
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // Only sync_ff and last_ff feed the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= evt_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign evt_pulse = sync_ff & ~last_ff;
endmodule

// >>> core/tif_regs.sv
// Timer interrupt request flags, first-timer priority and APB register file
//
// Overview of operation
// - Timer flags at bits 4,8,12,16,20
// - Flag register read/write, reset to zero
// - Timer one priority bits 4:2, zero disables
// - Timer one subpriority bits 1:0, reset zero
// - Foreign bit positions untouched by timer logic
`timescale 1ns/1ps
module tif_regs
  import tif_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  timer_event,
  output logic      [4:0]  timer_request_flags,
  output logic      [2:0]  timer_one_priority,
  output logic      [1:0]  timer_one_subpriority,
  output logic             timer_one_enabled,
  output logic             irq
);
  logic [31:0] flags_ff;
  logic [31:0] prio_ff;
  logic [4:0]  evt_st_ff;
  logic [4:0]  evt_msk_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_flags;
  logic [31:0] nxt_prdata;
  logic [31:0] wmask;
  logic [31:0] set_vec;
  logic [4:0]  evt_pulse;
  logic        wr_acc;
  logic        rd_acc;
  logic        addr_ok;

  // Single-cycle access phase, so pready is constant high
  assign pready  = 1'b1;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr == TIF_OFS_FLAGS) || (paddr == TIF_OFS_PRIO) ||
                   (paddr == TIF_OFS_EVT_ST) || (paddr == TIF_OFS_EVT_MSK) ||
                   (paddr == TIF_OFS_TIMER);
  assign pslverr = psel & penable & ~addr_ok;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wmask[8*g+7:8*g] = {8{pstrb[g]}};
    end
    for (g = 0; g < TIF_NUM_TIMERS; g++) begin : g_tmr
      tif_event_sync u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .evt_in    (timer_event[g]),
        .evt_pulse (evt_pulse[g])
      );
      assign timer_request_flags[g] = flags_ff[TIF_FLAG_POS[g]];
    end
  endgenerate

  always_comb begin
    set_vec = 32'h0000_0000;
    for (int i = 0; i < TIF_NUM_TIMERS; i++) begin
      set_vec[TIF_FLAG_POS[i]] = evt_pulse[i];
    end
  end

  always_comb begin
    nxt_flags = flags_ff;
    if (wr_acc && paddr == TIF_OFS_FLAGS) begin
      nxt_flags = (flags_ff & ~wmask) | (pwdata & wmask);
    end
    // Timer events touch only timer bits
    nxt_flags = nxt_flags | (set_vec & TIF_TIMER_MASK);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= TIF_FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_ff <= TIF_PRIO_RST;
    end else if (wr_acc && paddr == TIF_OFS_PRIO) begin
      prio_ff <= (prio_ff & ~wmask) | (pwdata & wmask);
    end
  end

  // Event status sticky, write one clears, new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_st_ff  <= TIF_EVT_RST;
      evt_msk_ff <= TIF_EVT_RST;
    end else begin
      if (wr_acc && paddr == TIF_OFS_EVT_ST && pstrb[0]) begin
        evt_st_ff <= (evt_st_ff & ~pwdata[4:0]) | evt_pulse;
      end else begin
        evt_st_ff <= evt_st_ff | evt_pulse;
      end
      if (wr_acc && paddr == TIF_OFS_EVT_MSK && pstrb[0]) begin
        evt_msk_ff <= pwdata[4:0];
      end
    end
  end

  assign timer_one_priority    = prio_ff[TIF_PRIO_MSB:TIF_PRIO_LSB];
  assign timer_one_subpriority = prio_ff[TIF_SUB_MSB:TIF_SUB_LSB];
  assign timer_one_enabled     = (timer_one_priority != 3'h0);
  assign irq = |(evt_st_ff & evt_msk_ff);

  always_comb begin
    nxt_prdata = prdata_ff;
    if (rd_acc) begin
      unique case (paddr)
        TIF_OFS_FLAGS:   nxt_prdata = flags_ff;
        TIF_OFS_PRIO:    nxt_prdata = prio_ff;
        TIF_OFS_EVT_ST:  nxt_prdata = {27'h0, evt_st_ff};
        TIF_OFS_EVT_MSK: nxt_prdata = {27'h0, evt_msk_ff};
        TIF_OFS_TIMER:   nxt_prdata = {27'h0, timer_request_flags};
        default:         nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data captured in setup so it is a flop output during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end
  assign prdata = prdata_ff;

  // Assertions
  // Register reads, setup then access
  sequence s_flag_rd_setup;
    psel && !penable && !pwrite && paddr == TIF_OFS_FLAGS;
  endsequence
  sequence s_prio_rd_setup;
    psel && !penable && !pwrite && paddr == TIF_OFS_PRIO;
  endsequence
  sequence s_rd_access;
    psel && penable && !pwrite;
  endsequence
  // Event pulse meeting a software write of the flags
  sequence s_clr_with_evt;
    wr_acc && paddr == TIF_OFS_FLAGS && set_vec != 32'h0000_0000;
  endsequence
  // Unmasked event while the mask is left alone
  sequence s_masked_evt;
    (evt_pulse & evt_msk_ff) != 5'h00 && !(wr_acc && paddr == TIF_OFS_EVT_MSK);
  endsequence

  // Flag register
  a_flag_set_evt: assert property (@(posedge pclk) disable iff (!presetn)
    evt_pulse[0] |=> flags_ff[TIF_FLAG_POS[0]]) else $error("timer one flag not set");
  a_flag_set_five: assert property (@(posedge pclk) disable iff (!presetn)
    evt_pulse[4] |=> flags_ff[TIF_FLAG_POS[4]]) else $error("timer five flag not set");
  a_set_beats_clr: assert property (@(posedge pclk) disable iff (!presetn)
    s_clr_with_evt |=> (flags_ff & $past(set_vec)) == $past(set_vec))
    else $error("event lost to flag write");
  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_acc && paddr == TIF_OFS_FLAGS) |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
    else $error("flag dropped without write");
  a_flag_write_val: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == TIF_OFS_FLAGS && pstrb == 4'hF && evt_pulse == 5'h00)
    |=> flags_ff == $past(pwdata)) else $error("flag write lost");
  a_flag_read_val: assert property (@(posedge pclk) disable iff (!presetn)
    s_flag_rd_setup ##1 s_rd_access |-> prdata == $past(flags_ff))
    else $error("flag read data wrong");
  a_foreign_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_acc && paddr == TIF_OFS_FLAGS) |=>
    (flags_ff & ~TIF_TIMER_MASK) == ($past(flags_ff) & ~TIF_TIMER_MASK))
    else $error("foreign flag changed");

  // Priority register
  a_prio_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == TIF_OFS_PRIO && pstrb[0]) |=>
    timer_one_priority == $past(pwdata[4:2])) else $error("priority not written");
  a_sub_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == TIF_OFS_PRIO && pstrb[0]) |=>
    timer_one_subpriority == $past(pwdata[1:0])) else $error("subpriority bad");
  a_prio_disable: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == TIF_OFS_PRIO && pstrb[0]) |=>
    timer_one_enabled == ($past(pwdata[TIF_PRIO_MSB:TIF_PRIO_LSB]) != 3'h0))
    else $error("enable mismatch");
  a_prio_read_val: assert property (@(posedge pclk) disable iff (!presetn)
    s_prio_rd_setup ##1 s_rd_access |-> prdata == $past(prio_ff))
    else $error("priority read data wrong");
  a_prio_foreign: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_acc && paddr == TIF_OFS_PRIO) |=> $stable(prio_ff))
    else $error("priority changed without write");

  // Event status and interrupt
  a_status_set: assert property (@(posedge pclk) disable iff (!presetn)
    evt_pulse != 5'h00 |=> (evt_st_ff & $past(evt_pulse)) == $past(evt_pulse))
    else $error("event status not set");
  a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
    s_masked_evt |=> irq) else $error("interrupt not raised");
endmodule

// >>> testbench/tb.sv
// Register-level bench for the timer interrupt flag block
`timescale 1ns/1ps
module tb;
  import tif_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [4:0]  timer_event = 5'h00;
  logic [31:0] prdata, rd, exp;
  logic        pready, pslverr, slv_err, timer_one_enabled, irq;
  logic [4:0]  timer_request_flags;
  logic [2:0]  timer_one_priority;
  logic [1:0]  timer_one_subpriority;
  int          failures = 0;
  int          samples_checked = 0;

  tif_regs tif_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .timer_event, .timer_request_flags, .timer_one_priority,
    .timer_one_subpriority, .timer_one_enabled, .irq);

  initial begin
    forever #2 pclk = ~pclk;
  end

  task automatic wrap_up;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; the wait is bounded so a dead slave cannot hang the run
  // An idle edge follows, so no strobe is driven twice in one time step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    rd = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, TIF_OFS_FLAGS, 32'h0);
    chk(rd, TIF_FLAGS_RST);
    xfer(1'b0, TIF_OFS_PRIO, 32'h0);
    chk(rd, TIF_PRIO_RST);
    xfer(1'b1, TIF_OFS_FLAGS, 32'hFFFF_FFFF);
    xfer(1'b0, TIF_OFS_FLAGS, 32'h0);
    chk(rd, 32'hFFFF_FFFF);
    chk({27'h0, timer_request_flags}, 32'h1F);
    xfer(1'b1, TIF_OFS_FLAGS, 32'h0);
    exp = 32'h0;
    // Sticky flags, one event at a time, foreign bits stay clear
    for (int i = 0; i < TIF_NUM_TIMERS; i++) begin
      timer_event <= 5'h01 << i;
      repeat (4) @(posedge pclk);
      timer_event <= 5'h00;
      exp[TIF_FLAG_POS[i]] = 1'b1;
      xfer(1'b0, TIF_OFS_FLAGS, 32'h0);
      chk(rd, exp);
    end
    xfer(1'b1, TIF_OFS_FLAGS, 32'h0011_1100);
    xfer(1'b0, TIF_OFS_FLAGS, 32'h0);
    chk(rd, 32'h0011_1100);
    chk({27'h0, timer_request_flags}, 32'h1E);
    // Every priority code; foreign bits kept as storage
    for (int p = 0; p < 8; p++) begin
      xfer(1'b1, TIF_OFS_PRIO, 32'hA5A5_A5E0 | (p << 2) | (p % 4));
      xfer(1'b0, TIF_OFS_PRIO, 32'h0);
      chk(rd, 32'hA5A5_A5E0 | (p << 2) | (p % 4));
      chk({26'h0, timer_one_enabled, timer_one_priority, timer_one_subpriority},
          {26'h0, p != 0, p[2:0], p[1:0]});
      chk({30'h0, timer_one_subpriority}, {30'h0, p[1:0]});
    end
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, TIF_OFS_EVT_MSK, 32'h04);
    xfer(1'b0, TIF_OFS_EVT_ST, 32'h0);
    chk(rd, 32'h1F);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, TIF_OFS_EVT_ST, 32'h04);
    xfer(1'b0, TIF_OFS_EVT_ST, 32'h0);
    chk(rd, 32'h1B);
    chk({31'h0, irq}, 32'h0);
    // Event reaches the flag on the edge where software clears it
    xfer(1'b1, TIF_OFS_FLAGS, 32'h0);
    timer_event <= 5'h04;
    @(posedge pclk);
    xfer(1'b1, TIF_OFS_FLAGS, 32'h0);
    timer_event <= 5'h00;
    xfer(1'b0, TIF_OFS_FLAGS, 32'h0);
    chk(rd, 32'h0000_1000);
    xfer(1'b0, TIF_OFS_EVT_ST, 32'h0);
    chk(rd, 32'h1F);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, slv_err}, 32'h1);
    // A second reset in mid-run clears every register again
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, TIF_OFS_FLAGS, 32'h0);
    chk(rd, TIF_FLAGS_RST);
    xfer(1'b0, TIF_OFS_PRIO, 32'h0);
    chk(rd, TIF_PRIO_RST);
    chk({26'h0, timer_one_enabled, timer_one_priority, timer_one_subpriority}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wrap_up();
  end
endmodule
